// ---- inc/fpt_consts.svh ----
/*
 Constants for the flash parameter table: serial framing values,
 table byte offsets and the fixed table contents.
 Assumes inclusion by bare name from design files.
*/
`ifndef FPT_CONSTS_SVH
`define FPT_CONSTS_SVH

// ====================================================
// serial framing
`define FPT_CMD_READ_TABLE  8'h5A
`define FPT_ADDR_BYTES      2'h3
`define FPT_LAST_BIT        3'h7
`define FPT_TABLE_TOP       16'h0000
`define FPT_FILL            8'hFF
`define FPT_ADDR_STEP       24'h000001
`define FPT_SIZE_ABSENT     8'h00
`define FPT_SIZE_4K         32'h00001000
`define FPT_SIZE_32K        32'h00008000
`define FPT_SIZE_64K        32'h00010000

// ====================================================
// table byte offsets
`define FPT_A_DOUT_WM   8'h3C
`define FPT_A_DOUT_OP   8'h3D
`define FPT_A_DIO_WM    8'h3E
`define FPT_A_DIO_OP    8'h3F
`define FPT_A_FULL_SUP  8'h40
`define FPT_A_ADUAL_WM  8'h46
`define FPT_A_ADUAL_OP  8'h47
`define FPT_A_AQUAD_WM  8'h4A
`define FPT_A_AQUAD_OP  8'h4B
`define FPT_A_ER1_SIZE  8'h4C
`define FPT_A_ER1_OP    8'h4D
`define FPT_A_ER2_SIZE  8'h4E
`define FPT_A_ER2_OP    8'h4F
`define FPT_A_ER3_SIZE  8'h50
`define FPT_A_ER3_OP    8'h51
`define FPT_A_ER4_SIZE  8'h52
`define FPT_A_ER4_OP    8'h53
`define FPT_A_VMAX_LO   8'h60
`define FPT_A_VMAX_HI   8'h61
`define FPT_A_VMIN_LO   8'h62
`define FPT_A_VMIN_HI   8'h63
`define FPT_A_FEAT_LO   8'h64
`define FPT_A_FEAT_HI   8'h65
`define FPT_A_WRAP_OP   8'h66
`define FPT_A_WRAP_LEN  8'h67
`define FPT_A_LOCK_LO   8'h68
`define FPT_A_LOCK_HI   8'h69

// ====================================================
// table contents
`define FPT_V_DOUT_WM   8'h08
`define FPT_V_DOUT_OP   8'h3B
`define FPT_V_DIO_WM    8'h42
`define FPT_V_DIO_OP    8'hBB
`define FPT_V_FULL_SUP  8'hEE
`define FPT_V_NONE_WM   8'h00
`define FPT_V_NONE_OP   8'hFF
`define FPT_V_ER1_SIZE  8'h0C
`define FPT_V_ER1_OP    8'h20
`define FPT_V_ER2_SIZE  8'h0F
`define FPT_V_ER2_OP    8'h52
`define FPT_V_ER3_SIZE  8'h10
`define FPT_V_ER3_OP    8'hD8
`define FPT_V_ER4_SIZE  8'h00
`define FPT_V_ER4_OP    8'hFF
`define FPT_V_VMAX      16'h3600
`define FPT_V_VMIN      16'h2300
`define FPT_V_FEAT      16'hF99E
`define FPT_V_WRAP_OP   8'h77
`define FPT_V_WRAP_LEN  8'h64
`define FPT_V_LOCK      16'hEBFC

`endif

// ---- inc/fpt_pkg.sv ----
/*
 Types for the flash parameter table block.
 Assumes fpt_consts.svh holds the numeric constants.
*/
package fpt_pkg;

    // ====================================================
    // serial pins, sampled as one group
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } fpt_pins_t;

    // ====================================================
    // serial slave phases
    typedef enum logic [2:0] {
        FPT_IDLE,
        FPT_CMD,
        FPT_ADDR,
        FPT_DUMMY,
        FPT_DATA,
        FPT_IGNORE
    } fpt_state_t;

endpackage : fpt_pkg

// ---- design/fpt_param_rom.sv ----
/*
 Fixed parameter table lookup: byte address in, table byte out.
 Assumes a registered address from the serial slave; pure logic.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpt_consts.svh"

module fpt_param_rom (
    input  wire logic [23:0] addr,
    output logic      [7:0]  data
);
    import fpt_pkg::*;

    // words split into bytes here, since a sized literal takes no part-select
    localparam logic [15:0] vmax_word = `FPT_V_VMAX;
    localparam logic [15:0] vmin_word = `FPT_V_VMIN;
    localparam logic [15:0] feat_word = `FPT_V_FEAT;
    localparam logic [15:0] lock_word = `FPT_V_LOCK;

    // ====================================================
    // lookup; constants only, no storage to corrupt
    always_comb begin
        data = `FPT_FILL;
        if (addr[23:8] == `FPT_TABLE_TOP) begin
            unique case (addr[7:0])
                `FPT_A_DOUT_WM:  data = `FPT_V_DOUT_WM;
                `FPT_A_DOUT_OP:  data = `FPT_V_DOUT_OP;
                `FPT_A_DIO_WM:   data = `FPT_V_DIO_WM;
                `FPT_A_DIO_OP:   data = `FPT_V_DIO_OP;
                `FPT_A_FULL_SUP: data = `FPT_V_FULL_SUP;
                `FPT_A_ADUAL_WM: data = `FPT_V_NONE_WM;
                `FPT_A_AQUAD_WM: data = `FPT_V_NONE_WM;
                `FPT_A_ADUAL_OP: data = `FPT_V_NONE_OP;
                `FPT_A_AQUAD_OP: data = `FPT_V_NONE_OP;
                `FPT_A_ER1_SIZE: data = `FPT_V_ER1_SIZE;
                `FPT_A_ER1_OP:   data = `FPT_V_ER1_OP;
                `FPT_A_ER2_SIZE: data = `FPT_V_ER2_SIZE;
                `FPT_A_ER2_OP:   data = `FPT_V_ER2_OP;
                `FPT_A_ER3_SIZE: data = `FPT_V_ER3_SIZE;
                `FPT_A_ER3_OP:   data = `FPT_V_ER3_OP;
                `FPT_A_ER4_SIZE: data = `FPT_V_ER4_SIZE;
                `FPT_A_ER4_OP:   data = `FPT_V_ER4_OP;
                `FPT_A_VMAX_LO:  data = vmax_word[7:0];
                `FPT_A_VMAX_HI:  data = vmax_word[15:8];
                `FPT_A_VMIN_LO:  data = vmin_word[7:0];
                `FPT_A_VMIN_HI:  data = vmin_word[15:8];
                `FPT_A_FEAT_LO:  data = feat_word[7:0];
                `FPT_A_FEAT_HI:  data = feat_word[15:8];
                `FPT_A_WRAP_OP:  data = `FPT_V_WRAP_OP;
                `FPT_A_WRAP_LEN: data = `FPT_V_WRAP_LEN;
                `FPT_A_LOCK_LO:  data = lock_word[7:0];
                `FPT_A_LOCK_HI:  data = lock_word[15:8];
                default:         data = `FPT_FILL;
            endcase
        end
    end

endmodule : fpt_param_rom
`default_nettype wire

// ---- design/fpt_table_slave.sv ----
/*
 Serial slave that answers the parameter table read command.
 Pins are sampled with the system clock through two flops; the
 serial clock must stay well below a quarter of clk (about 25 MHz).
 Mode 0 and mode 3: input taken on sclk rise, output on sclk fall.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpt_consts.svh"

module fpt_table_slave (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire fpt_pkg::fpt_pins_t pins,
    output logic                  so_o,
    output logic                  so_oe
);
    import fpt_pkg::*;

    // ====================================================
    // pin synchroniser and edge detect

    fpt_pins_t  sync1_q;
    fpt_pins_t  sync2_q;
    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       selected;

    // two flops; only the second stage feeds logic
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
            sync2_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // previous serial clock level for edges
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sync2_q.sclk;
        end
    end

    // edges only count while selected
    assign selected  = !sync2_q.cs_n;
    assign sclk_rise = selected & sync2_q.sclk & !sclk_prev_q;
    assign sclk_fall = selected & !sync2_q.sclk & sclk_prev_q;

    // ====================================================
    // bit and byte counting on the input side

    fpt_state_t state_q;
    fpt_state_t state_d;
    logic [7:0] shift_q;
    logic [7:0] shift_in;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic       byte_done;

    // the byte as it stands after this rising edge
    assign shift_in  = {shift_q[6:0], sync2_q.si};
    assign byte_done = sclk_rise && (bit_cnt_q == `FPT_LAST_BIT);

    // input shifter, msb first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_q <= 8'h00;
        end else if (sclk_rise) begin
            shift_q <= shift_in;
        end
    end

    // bit counter: restarts with every frame
    always_ff @(posedge clk) begin
        if (!resetn || !selected) begin
            bit_cnt_q <= 3'h0;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // address byte counter
    always_ff @(posedge clk) begin
        if (!resetn || state_q != FPT_ADDR) begin
            byte_cnt_q <= 2'h0;
        end else if (byte_done) begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
        end
    end

    // ====================================================
    // frame state machine

    // the command decides everything; anything else is ignored
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FPT_IDLE: begin
                if (selected) begin
                    state_d = FPT_CMD;
                end
            end
            FPT_CMD: begin
                if (byte_done) begin
                    if (shift_in == `FPT_CMD_READ_TABLE) begin
                        state_d = FPT_ADDR;
                    end else begin
                        state_d = FPT_IGNORE;
                    end
                end
            end
            FPT_ADDR: begin
                if (byte_done && byte_cnt_q == `FPT_ADDR_BYTES - 2'h1) begin
                    state_d = FPT_DUMMY;
                end
            end
            FPT_DUMMY: begin
                if (byte_done) begin
                    state_d = FPT_DATA;
                end
            end
            FPT_DATA: begin
                state_d = FPT_DATA;
            end
            FPT_IGNORE: begin
                state_d = FPT_IGNORE;
            end
            default: begin
                state_d = FPT_IDLE;
            end
        endcase
        // deselect always ends the frame
        if (!selected) begin
            state_d = FPT_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= FPT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ====================================================
    // table address and read-out

    logic [23:0] addr_q;
    logic [7:0]  rom_byte;
    logic [2:0]  out_cnt_q;
    logic        so_q;
    logic        so_oe_q;

    fpt_param_rom u_rom (
        .addr (addr_q),
        .data (rom_byte)
    );

    // address collects msb byte first, then steps per byte out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_q <= 24'h000000;
        end else if (state_q == FPT_ADDR && byte_done) begin
            addr_q <= {addr_q[15:0], shift_in};
        end else if (state_q == FPT_DATA && sclk_fall
                     && out_cnt_q == `FPT_LAST_BIT) begin
            addr_q <= addr_q + `FPT_ADDR_STEP;
        end
    end

    // output bit counter for the byte being shifted out
    always_ff @(posedge clk) begin
        if (!resetn || state_q != FPT_DATA) begin
            out_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            out_cnt_q <= out_cnt_q + 3'h1;
        end
    end

    // data bit; the table is read straight, never written
    always_ff @(posedge clk) begin
        if (!resetn) begin
            so_q <= 1'b0;
        end else if (state_q == FPT_DATA && sclk_fall) begin
            so_q <= rom_byte[~out_cnt_q];
        end
    end

    // drive only from first data fall until deselect
    always_ff @(posedge clk) begin
        if (!resetn || !selected) begin
            so_oe_q <= 1'b0;
        end else if (state_q == FPT_DATA && sclk_fall) begin
            so_oe_q <= 1'b1;
        end
    end

    assign so_o  = so_q;
    assign so_oe = so_oe_q;

    // ====================================================
    // checks on table contents

    a_dual_out_wait: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_DOUT_WM}
        |-> rom_byte == `FPT_V_DOUT_WM
    ) else $error("dual output wait byte wrong");

    a_dual_out_op: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_DOUT_OP}
        |-> rom_byte == `FPT_V_DOUT_OP
    ) else $error("dual output opcode wrong");

    a_dual_io_wait: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_DIO_WM}
        |-> rom_byte[4:0] == 5'h02 && rom_byte[7:5] == 3'h2
    ) else $error("dual io wait/mode byte wrong");

    a_dual_io_op: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_DIO_OP}
        |-> rom_byte == `FPT_V_DIO_OP
    ) else $error("dual io opcode wrong");

    a_full_width_off: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_FULL_SUP}
        |-> !rom_byte[0] && !rom_byte[4]
    ) else $error("full width mode claimed");

    a_full_width_op: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q inside {{16'h0000, `FPT_A_ADUAL_OP},
                       {16'h0000, `FPT_A_AQUAD_OP}}
        |-> rom_byte == `FPT_FILL
    ) else $error("unsupported mode opcode not FF");

    // size exponents decode to the documented erase sizes
    a_erase_sizes: assert property (
        @(posedge clk) disable iff (!resetn)
        (addr_q != {16'h0000, `FPT_A_ER1_SIZE} || (32'h1 << rom_byte) == `FPT_SIZE_4K)
        && (addr_q != {16'h0000, `FPT_A_ER2_SIZE} || (32'h1 << rom_byte) == `FPT_SIZE_32K)
        && (addr_q != {16'h0000, `FPT_A_ER3_SIZE} || (32'h1 << rom_byte) == `FPT_SIZE_64K)
        && (addr_q != {16'h0000, `FPT_A_ER4_SIZE} || rom_byte == `FPT_SIZE_ABSENT)
    ) else $error("erase size exponent wrong");

    a_erase_one: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_ER1_OP}
        |-> rom_byte == `FPT_V_ER1_OP
    ) else $error("erase type one opcode wrong");

    a_erase_two: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_ER2_SIZE}
        |-> rom_byte == `FPT_V_ER2_SIZE
    ) else $error("erase type two size wrong");

    a_erase_three: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_ER3_OP}
        |-> rom_byte == `FPT_V_ER3_OP
    ) else $error("erase type three opcode wrong");

    a_erase_four: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_ER4_SIZE}
        |-> rom_byte == `FPT_SIZE_ABSENT
    ) else $error("erase type four not absent");

    a_supply_max: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_VMAX_HI}
        |-> rom_byte == 8'h36
    ) else $error("supply max high byte wrong");

    a_feature_word: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_FEAT_LO}
        |-> rom_byte == 8'h9E
    ) else $error("feature word low byte wrong");

    a_wrap_opcode: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_WRAP_OP}
        |-> rom_byte == `FPT_V_WRAP_OP
    ) else $error("wrap opcode wrong");

    a_wrap_length: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_WRAP_LEN}
        |-> rom_byte == `FPT_V_WRAP_LEN
    ) else $error("wrap length byte wrong");

    a_lock_word: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q == {16'h0000, `FPT_A_LOCK_HI}
        |-> rom_byte == 8'hEB
    ) else $error("lock word high byte wrong");

    a_fill_unused: assert property (
        @(posedge clk) disable iff (!resetn)
        addr_q[23:8] != 16'h0000
        |-> rom_byte == `FPT_FILL
    ) else $error("out of table byte not FF");

    // ====================================================
    // checks on framing

    a_bad_cmd: assert property (
        @(posedge clk) disable iff (!resetn)
        state_q == FPT_CMD && byte_done && selected
        && shift_in != `FPT_CMD_READ_TABLE
        |=> state_q == FPT_IGNORE
    ) else $error("foreign command not ignored");

    a_addr_entry: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(state_q == FPT_ADDR)
        |-> $past(shift_in) == `FPT_CMD_READ_TABLE
    ) else $error("address phase without read command");

    a_stable_table: assert property (
        @(posedge clk) disable iff (!resetn)
        $stable(addr_q) |-> $stable(rom_byte)
    ) else $error("table byte changed on its own");

    a_release_bus: assert property (
        @(posedge clk) disable iff (!resetn)
        !selected |=> !so_oe && state_q == FPT_IDLE
    ) else $error("output still driven after deselect");

endmodule : fpt_table_slave
`default_nettype wire

// ---- testbench/fpt_host_model.sv ----
/*
 Host controller model that reads the parameter tables over the serial pins.
 Assumes a 100 MHz clk; sclk runs in mode 0, or mode 3 when cpol is set,
 at 10 clk per period.
*/
`timescale 1ns/10ps
`default_nettype none

module fpt_host_model (
    input  wire logic                 clk,
    output var  fpt_pkg::fpt_pins_t   pins,
    input  wire logic                 so,
    input  wire logic                 so_oe
);
    import fpt_pkg::*;

    // ==========================================================
    // capture state read back by the bench
    logic [7:0] rx [$];
    logic       oe_hdr;
    int         oe_hi_cnt;
    logic       cpol;

    // idle bus: deselected, clock parked low
    initial begin
        pins = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
        cpol = 1'b0;
        oe_hdr = 1'b0;
        oe_hi_cnt = 0;
    end

    // ==========================================================
    // one sclk period: data set while low, sampled just before the rise
    // five clk per level keeps us above the slave's oversampling floor
    task automatic shift_bit(input logic b, output logic r, output logic e);
        pins.sclk = 1'b0;
        pins.si = b;
        repeat (5) @(negedge clk);
        r = (so_oe === 1'b1) ? so : ~so; // an undriven line never shows the last bit
        e = so_oe;
        pins.sclk = 1'b1;
        repeat (5) @(negedge clk);
    endtask : shift_bit

    // frame: command, three address bytes MSB first, eight dummy clocks
    // hbits below 40 cuts the header short and reads nothing
    task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int hbits, input int n);
        logic [39:0] hdr;
        logic [7:0]  b;
        logic        r;
        logic        e;
        hdr = {cmd, addr, 8'h00};
        rx = {};
        oe_hdr = 1'b0;
        oe_hi_cnt = 0;
        // park the clock at its idle level before select, so no false edge
        pins.sclk = cpol;
        repeat (2) @(negedge clk);
        pins.cs_n = 1'b0;
        for (int i = 39; i >= 40 - hbits; i--) begin
            shift_bit(hdr[i], r, e);
            oe_hdr = oe_hdr | e;
        end
        for (int j = 0; j < n && hbits == 40; j++) begin
            for (int k = 7; k >= 0; k--) begin
                shift_bit(~pins.si, r, e); // si carries no meaning here, so keep it toggling
                b[k] = r;
                if (e === 1'b1) begin
                    oe_hi_cnt++;
                end
            end
            rx.push_back(b);
        end
        pins.sclk = cpol;
        repeat (5) @(negedge clk);
        pins.cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : frame

endmodule : fpt_host_model

`default_nettype wire

// ---- testbench/tb.sv ----
/*
 Self-checking bench for the parameter table slave.
 Assumes fpt_host_model as the far side; all pins driven at clk fall.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
    import fpt_pkg::*;

    // ==========================================================
    // clock, reset, counters
    logic      clk;
    logic      resetn;
    fpt_pins_t pins;
    logic      so_o;
    logic      so_oe;
    int        failures;
    int        check_count;
    int        cycles = 0;

    fpt_table_slave uut (
        .clk    (clk),
        .resetn (resetn),
        .pins   (pins),
        .so_o   (so_o),
        .so_oe  (so_oe)
    );

    fpt_host_model host (
        .clk   (clk),
        .pins  (pins),
        .so    (so_o),
        .so_oe (so_oe)
    );

    always #5 clk = ~clk;

    // hang guard: a full run takes about 10300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            results();
        end
    end

    // ==========================================================
    // expected table image, full 24-bit decode
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        logic [7:0] v;
        v = 8'hFF; // unlisted bytes read as erased
        if (a[23:8] == 16'h0000) begin
            case (a[7:0])
                8'h3C: v = 8'h08;
                8'h3D: v = 8'h3B;
                8'h3E: v = 8'h42;
                8'h3F: v = 8'hBB;
                8'h40: v = 8'hEE;
                8'h46: v = 8'h00;
                8'h4A: v = 8'h00;
                8'h4C: v = 8'h0C;
                8'h4D: v = 8'h20;
                8'h4E: v = 8'h0F;
                8'h4F: v = 8'h52;
                8'h50: v = 8'h10;
                8'h51: v = 8'hD8;
                8'h52: v = 8'h00;
                8'h60: v = 8'h00;
                8'h61: v = 8'h36;
                8'h62: v = 8'h00;
                8'h63: v = 8'h23;
                8'h64: v = 8'h9E;
                8'h65: v = 8'hF9;
                8'h66: v = 8'h77;
                8'h67: v = 8'h64;
                8'h68: v = 8'hFC;
                8'h69: v = 8'hEB;
                default: v = 8'hFF;
            endcase
        end
        return v;
    endfunction : exp_byte

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // burst read, byte compare, enable behaviour around the frame
    task automatic read_cmp(input logic [23:0] addr, input int n);
        host.frame(8'h5A, addr, 40, n);
        check({31'h0, host.oe_hdr}, 32'h0);
        check(host.oe_hi_cnt, n * 8);
        check({31'h0, so_oe}, 32'h0);
        for (int i = 0; i < n; i++) begin
            check({24'h0, host.rx[i]}, {24'h0, exp_byte(addr + i[23:0])});
        end
    endtask : read_cmp

    // ==========================================================
    // scenarios
    task automatic test_jedec_tail;
        read_cmp(24'h00003C, 24);
        // size bytes are exponents: decoded sizes must match the erase kinds
        check(32'h1 << host.rx[16], 32'h00001000);
        check(32'h1 << host.rx[18], 32'h00008000);
        check(32'h1 << host.rx[20], 32'h00010000);
        check({24'h0, host.rx[22]}, 32'h0);
    endtask : test_jedec_tail

    task automatic test_vendor;
        read_cmp(24'h000060, 12);
    endtask : test_vendor

    task automatic test_unmapped;
        read_cmp(24'h01003C, 2);
        read_cmp(24'hFFFFFE, 3);
        read_cmp(24'h000041, 9);
    endtask : test_unmapped

    // any other command must leave the output undriven
    task automatic test_refused;
        host.frame(8'h03, 24'h00003C, 40, 2);
        check({31'h0, host.oe_hdr}, 32'h0);
        check(host.oe_hi_cnt, 0);
        host.frame(8'h5B, 24'h00003C, 40, 1);
        check(host.oe_hi_cnt, 0);
    endtask : test_refused

    // idle-high clock: the fall right after select must not shift data
    task automatic test_mode3;
        host.cpol = 1'b1;
        read_cmp(24'h00004C, 8);
        host.cpol = 1'b0;
    endtask : test_mode3

    // a cut frame, then a reset mid-frame: neither may disturb the table
    task automatic test_abort_reset;
        host.frame(8'h5A, 24'h00003C, 20, 0);
        read_cmp(24'h00003D, 2);
        fork
            host.frame(8'h5A, 24'h000064, 40, 2);
            begin
                repeat (150) @(negedge clk);
                resetn = 1'b0;
                repeat (5) @(negedge clk);
                check({31'h0, so_oe}, 32'h0);
                resetn = 1'b1;
            end
        join
        read_cmp(24'h000064, 4);
    endtask : test_abort_reset

    // ==========================================================
    // verdict and run end
    task automatic results;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        failures = 0;
        check_count = 0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        test_jedec_tail();
        test_vendor();
        test_unmapped();
        test_refused();
        test_mode3();
        test_abort_reset();
        results();
    end

endmodule : tb

`default_nettype wire
